//--- hdl/sbr_rate_generator.sv
// serial baud rate generator: 8-bit timer, fixed prescaler and AXI4-Lite register slave
//
// Operation
// [RULE1] one generator serves async and sync modes
// [RULE2] free-running 8-bit timer, period from divisor
// [RULE3] async: high-speed bit selects divide ratio
// [RULE4] sync: high-speed bit ignored
// [RULE5] rate applies only when clock internal
// [RULE6] async rate fosc/64(n+1) or fosc/16(n+1)
// [RULE7] sync master rate fosc/4(n+1)
// [RULE8] divisor write clears timer at once
// [RULE9] every divisor 0 to 255 accepted
// [RULE10] software may prefer high speed for accuracy
// [RULE11] divisor resets to zero
// [RULE12] mode bit 4 high selects synchronous
// [RULE13] clock-source bit 7 selects master or slave
// [RULE14] timer reloads on expiry, tick feeds prescaler
`timescale 1ns/100ps

module sbr_rate_generator
  import sbr_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [SBR_ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]              awprot,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [SBR_DATA_W-1:0]   wdata,
  input  wire logic [SBR_DATA_W/8-1:0] wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [SBR_ADDR_W-1:0]   araddr,
  input  wire logic [2:0]              arprot,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [SBR_DATA_W-1:0]        rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic                    shift_empty,
  output sbr_mode_type                 mode,
  output logic                         rate_tick,
  output logic                         bit_tick
);

  // ----------------------------------------------------------------
  // constants and state
  // ----------------------------------------------------------------
  localparam logic [SBR_PRE_W-1:0] PRE_LIM_LOW  = SBR_PRE_W'(SBR_PRE_ASYNC_LOW - 1);
  localparam logic [SBR_PRE_W-1:0] PRE_LIM_HIGH = SBR_PRE_W'(SBR_PRE_ASYNC_HIGH - 1);
  localparam logic [SBR_PRE_W-1:0] PRE_LIM_SYNC = SBR_PRE_W'(SBR_PRE_SYNC - 1);
  logic                  aw_held;
  logic                  w_held;
  logic [7:0]            aw_index;
  logic                  aw_mapped;
  logic [7:0]            w_byte;
  logic                  w_lane0;
  logic [7:0]            rx_ctrl;
  logic [7:0]            tx_ctrl;
  logic [7:0]            baud_divisor;
  logic [7:0]            timer;
  logic [SBR_PRE_W-1:0]  prescale;
  logic                  next_aw_held;
  logic                  next_w_held;
  logic [7:0]            next_aw_index;
  logic                  next_aw_mapped;
  logic [7:0]            next_w_byte;
  logic                  next_w_lane0;
  logic [7:0]            next_rx_ctrl;
  logic [7:0]            next_tx_ctrl;
  logic [7:0]            next_baud_divisor;
  logic [7:0]            next_timer;
  logic [SBR_PRE_W-1:0]  next_prescale;
  logic                  next_awready;
  logic                  next_wready;
  logic [1:0]            next_bresp;
  logic                  next_bvalid;
  logic                  next_arready;
  logic [SBR_DATA_W-1:0] next_rdata;
  logic [1:0]            next_rresp;
  logic                  next_rvalid;
  sbr_mode_type          next_mode;
  logic                  next_rate_tick;
  logic                  next_bit_tick;

  // helpers shared by the next-state logic and the checks
  logic                  wr_fire;
  logic                  div_write;
  logic                  expire;
  logic                  gen_enable;
  logic [SBR_PRE_W-1:0]  pre_limit;

  // ----------------------------------------------------------------
  // address decode and rate selection
  // ----------------------------------------------------------------
  // upper address bits above the index field must be zero to hit a register
  function automatic logic addr_mapped(input logic [SBR_ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    addr_mapped = (addr[SBR_ADDR_W-1:10] == '0) &&
                  (idx == SBR_IDX_RX_CTRL || idx == SBR_IDX_TX_CTRL ||
                   idx == SBR_IDX_DIVISOR || idx == SBR_IDX_STATUS);
  endfunction

  // sync mode ignores the high-speed bit; async picks 64 or 16
  always_comb begin
    if (tx_ctrl[SBR_TX_SYNC_BIT]) begin
      pre_limit = PRE_LIM_SYNC;                          // [RULE4] [RULE7] [RULE12]
    end else if (tx_ctrl[SBR_TX_HS_BIT]) begin
      pre_limit = PRE_LIM_HIGH;                          // [RULE3] [RULE6]
    end else begin
      pre_limit = PRE_LIM_LOW;                           // [RULE6]
    end
  end

  // same timer serves both modes; only a sync slave takes its clock from outside
  assign gen_enable = !tx_ctrl[SBR_TX_SYNC_BIT] ||
                      tx_ctrl[SBR_TX_MASTER_BIT];        // [RULE1] [RULE5] [RULE13]
  assign wr_fire    = aw_held && w_held && !bvalid;
  assign div_write  = wr_fire && aw_mapped && w_lane0 && (aw_index == SBR_IDX_DIVISOR);
  assign expire     = (timer == baud_divisor);           // [RULE2] [RULE9]

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // address and data are captured independently, so either may come first
  always_comb begin
    next_aw_held      = aw_held;
    next_w_held       = w_held;
    next_aw_index     = aw_index;
    next_aw_mapped    = aw_mapped;
    next_w_byte       = w_byte;
    next_w_lane0      = w_lane0;
    next_rx_ctrl      = rx_ctrl;
    next_tx_ctrl      = tx_ctrl;
    next_baud_divisor = baud_divisor;
    next_bresp        = bresp;
    next_bvalid       = bvalid;
    next_rdata        = rdata;
    next_rresp        = rresp;
    next_rvalid       = rvalid;
    if (awvalid && awready) begin
      next_aw_held   = 1'b1;
      next_aw_index  = awaddr[9:2];
      next_aw_mapped = addr_mapped(awaddr);
    end
    if (wvalid && wready) begin
      next_w_held  = 1'b1;
      next_w_byte  = wdata[7:0];
      next_w_lane0 = wstrb[0];
    end
    // commit the write once both halves are held; only lane 0 carries data
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = aw_mapped ? SBR_RESP_OKAY : SBR_RESP_SLVERR;
      if (aw_mapped && w_lane0) begin
        case (aw_index)
          SBR_IDX_RX_CTRL: next_rx_ctrl = w_byte & SBR_RX_WR_MASK;
          SBR_IDX_TX_CTRL: next_tx_ctrl = w_byte & SBR_TX_WR_MASK;
          SBR_IDX_DIVISOR: next_baud_divisor = w_byte;   // [RULE9]
          default:         next_rx_ctrl = rx_ctrl;       // status is read-only
        endcase
      end
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // read data is sampled at the address handshake
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = addr_mapped(araddr) ? SBR_RESP_OKAY : SBR_RESP_SLVERR;
      next_rdata  = '0;
      if (addr_mapped(araddr)) begin
        case (araddr[9:2])
          SBR_IDX_RX_CTRL: next_rdata = {24'h000000, rx_ctrl};
          SBR_IDX_TX_CTRL: next_rdata = {24'h000000, tx_ctrl[7:2], shift_empty, tx_ctrl[0]};
          SBR_IDX_DIVISOR: next_rdata = {24'h000000, baud_divisor};
          default:         next_rdata = {18'h00000, prescale, timer};
        endcase
      end
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    // ready drops while a half is held or a response waits
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end
  // timer counts 0..divisor then reloads; a divisor write restarts it at once
  always_comb begin
    next_timer     = timer + 8'h01;                      // [RULE2]
    next_prescale  = prescale;
    next_rate_tick = 1'b0;
    next_bit_tick  = 1'b0;
    if (div_write) begin
      next_timer    = 8'h00;                             // [RULE8]
      next_prescale = '0;                                // [RULE8]
    end else if (expire) begin
      next_timer     = 8'h00;                            // [RULE14]
      next_rate_tick = 1'b1;                             // [RULE14]
      // >= so that a mode change to a shorter ratio never overruns
      if (prescale >= pre_limit) begin
        next_prescale = '0;
        next_bit_tick = gen_enable;                      // [RULE5] [RULE14]
      end else begin
        next_prescale = prescale + SBR_PRE_W'(1);
      end
    end
  end
  // mode outputs follow the control register without a cycle of lag
  always_comb begin
    next_mode.sync_mode           = next_tx_ctrl[SBR_TX_SYNC_BIT];   // [RULE12]
    next_mode.clock_source_master = next_tx_ctrl[SBR_TX_MASTER_BIT]; // [RULE13]
    next_mode.high_speed_select   = next_tx_ctrl[SBR_TX_HS_BIT];
    next_mode.serial_enable       = next_rx_ctrl[SBR_RX_ENABLE_BIT];
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_index     <= 8'h00;
      aw_mapped    <= 1'b0;
      w_byte       <= 8'h00;
      w_lane0      <= 1'b0;
      rx_ctrl      <= SBR_RX_CTRL_RST;
      tx_ctrl      <= SBR_TX_CTRL_RST & SBR_TX_WR_MASK;
      baud_divisor <= SBR_DIVISOR_RST;                   // [RULE11]
      timer        <= 8'h00;
      prescale     <= '0;
      awready      <= 1'b0;
      wready       <= 1'b0;
      bresp        <= SBR_RESP_OKAY;
      bvalid       <= 1'b0;
      arready      <= 1'b0;
      rdata        <= '0;
      rresp        <= SBR_RESP_OKAY;
      rvalid       <= 1'b0;
      mode         <= '0;
      rate_tick    <= 1'b0;
      bit_tick     <= 1'b0;
    end else begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_index     <= next_aw_index;
      aw_mapped    <= next_aw_mapped;
      w_byte       <= next_w_byte;
      w_lane0      <= next_w_lane0;
      rx_ctrl      <= next_rx_ctrl;
      tx_ctrl      <= next_tx_ctrl;
      baud_divisor <= next_baud_divisor;
      timer        <= next_timer;
      prescale     <= next_prescale;
      awready      <= next_awready;
      wready       <= next_wready;
      bresp        <= next_bresp;
      bvalid       <= next_bvalid;
      arready      <= next_arready;
      rdata        <= next_rdata;
      rresp        <= next_rresp;
      rvalid       <= next_rvalid;
      mode         <= next_mode;
      rate_tick    <= next_rate_tick;
      bit_tick     <= next_bit_tick;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_div_clear;
    @(posedge aclk) disable iff (!aresetn)
      div_write |=> (timer == 8'h00) && (prescale == '0) && !rate_tick;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("timer not restarted"); // [RULE8]
  property p_timer_bound;
    @(posedge aclk) disable iff (!aresetn)
      timer <= baud_divisor;
  endproperty
  a_timer_bound: assert property (p_timer_bound) else $error("timer ran past divisor"); // [RULE2]
  property p_expire_tick;
    @(posedge aclk) disable iff (!aresetn)
      (expire && !div_write) |=> rate_tick && (timer == 8'h00);
  endproperty
  a_expire_tick: assert property (p_expire_tick) else $error("expiry gave no tick"); // [RULE14]
  // the bit tick must follow the 64th expiry in low speed async, no sooner or later
  property p_async_low;
    @(posedge aclk) disable iff (!aresetn)
      (!tx_ctrl[SBR_TX_SYNC_BIT] && !tx_ctrl[SBR_TX_HS_BIT] && expire && !div_write) |=>
        (bit_tick == ($past(prescale) >= 6'h3F));
  endproperty
  a_async_low: assert property (p_async_low) else $error("bit tick not at 64"); // [RULE6]
  property p_async_high;
    @(posedge aclk) disable iff (!aresetn)
      (!tx_ctrl[SBR_TX_SYNC_BIT] && tx_ctrl[SBR_TX_HS_BIT] && expire && !div_write) |=>
        (bit_tick == ($past(prescale) >= 6'h0F));
  endproperty
  a_async_high: assert property (p_async_high) else $error("bit tick not at 16"); // [RULE3]
  // sync master divides by 4 whatever the high-speed bit says
  property p_sync_ratio;
    @(posedge aclk) disable iff (!aresetn)
      (tx_ctrl[SBR_TX_SYNC_BIT] && tx_ctrl[SBR_TX_MASTER_BIT] && expire && !div_write) |=>
        (bit_tick == ($past(prescale) >= 6'h03));
  endproperty
  a_sync_ratio: assert property (p_sync_ratio) else $error("bit tick not at 4"); // [RULE7]
  property p_slave_quiet;
    @(posedge aclk) disable iff (!aresetn)
      $past(tx_ctrl[SBR_TX_SYNC_BIT] && !tx_ctrl[SBR_TX_MASTER_BIT]) |-> !bit_tick;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("bit tick in sync slave"); // [RULE5]
  property p_bit_tick_cause;
    @(posedge aclk) disable iff (!aresetn)
      bit_tick |-> rate_tick && $past(prescale >= pre_limit) && (prescale == '0);
  endproperty
  a_bit_tick_cause: assert property (p_bit_tick_cause) else $error("stray bit tick"); // [RULE1]
  property p_div_reset;
    @(posedge aclk) !aresetn |=> (baud_divisor == 8'h00) && (timer == 8'h00);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divisor not reset"); // [RULE11]
  property p_mode_follow;
    @(posedge aclk) disable iff (!aresetn)
      (mode.sync_mode == tx_ctrl[SBR_TX_SYNC_BIT]) &&
      (mode.clock_source_master == tx_ctrl[SBR_TX_MASTER_BIT]);
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("mode off control"); // [RULE12]

endmodule

//--- hdl/sbr_pkg.sv
// package for the serial baud rate generator: register map, fields, resets and carriers
package sbr_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned SBR_ADDR_W = 12;
  localparam int unsigned SBR_DATA_W = 32;

  // ----------------------------------------------------------------
  // register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] SBR_IDX_RX_CTRL = 8'h18;
  localparam logic [7:0] SBR_IDX_TX_CTRL = 8'h98;
  localparam logic [7:0] SBR_IDX_DIVISOR = 8'h99;
  localparam logic [7:0] SBR_IDX_STATUS  = 8'h9A;

  // ----------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] SBR_RX_CTRL_RST = 8'h00;
  localparam logic [7:0] SBR_TX_CTRL_RST = 8'h02;
  localparam logic [7:0] SBR_DIVISOR_RST = 8'h00;
  localparam logic [7:0] SBR_RX_WR_MASK  = 8'hF8;
  localparam logic [7:0] SBR_TX_WR_MASK  = 8'hF5;

  // ----------------------------------------------------------------
  // field positions in the transmit and receive control registers
  // ----------------------------------------------------------------
  localparam int unsigned SBR_TX_MASTER_BIT = 7;
  localparam int unsigned SBR_TX_SYNC_BIT   = 4;
  localparam int unsigned SBR_TX_HS_BIT     = 2;
  localparam int unsigned SBR_TX_EMPTY_BIT  = 1;
  localparam int unsigned SBR_RX_ENABLE_BIT = 7;

  // ----------------------------------------------------------------
  // fixed prescale ratios behind the 8-bit timer
  // ----------------------------------------------------------------
  localparam int unsigned SBR_PRE_W          = 6;
  localparam int unsigned SBR_PRE_ASYNC_LOW  = 64;
  localparam int unsigned SBR_PRE_ASYNC_HIGH = 16;
  localparam int unsigned SBR_PRE_SYNC       = 4;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] SBR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SBR_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // mode selects handed to the shift logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync_mode;
    logic clock_source_master;
    logic high_speed_select;
    logic serial_enable;
  } sbr_mode_type;

endpackage

//--- dv/sbr_shift_model.sv
// partner model: transmit shift logic that consumes the bit tick
`timescale 1ns/100ps

module sbr_shift_model
  import sbr_pkg::*;
#(
  parameter int unsigned FRAME_BITS = 10
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire sbr_mode_type mode,
  input  wire logic         bit_tick,
  input  wire logic         load,
  output logic              shift_empty
);
  int unsigned left;

  // a loaded frame keeps the shifter full until its bits are gone;
  // a disabled port never starts a frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left <= 0;
    end else if (load && mode.serial_enable) begin
      left <= FRAME_BITS;
    end else if (bit_tick && left != 0) begin
      left <= left - 1;
    end
  end

  assign shift_empty = (left == 0);
endmodule

//--- dv/test_serial_baud_rate_generator.sv
// testbench for the serial baud rate generator
`timescale 1ns/100ps

module test_serial_baud_rate_generator
  import sbr_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, shift_empty, rate_tick, bit_tick, load;
  logic [SBR_ADDR_W-1:0] awaddr, araddr;
  logic [SBR_DATA_W-1:0] wdata, rdata;
  logic [1:0]            bresp, rresp;
  sbr_mode_type          mode;
  int                    n_errors, tests_run;

  sbr_rate_generator i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .shift_empty(shift_empty),
    .mode(mode), .rate_tick(rate_tick), .bit_tick(bit_tick));

  sbr_shift_model i_far (.aclk(aclk), .aresetn(aresetn), .mode(mode),
    .bit_tick(bit_tick), .load(load), .shift_empty(shift_empty));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // handshakes are judged at the negedge, which shows what the next edge samples
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask

  // cycles until the chosen tick is seen; returns lim if it never comes
  task automatic gap(input logic bt, input int lim, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (n < lim && (bt ? bit_tick : rate_tick) !== 1'b1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(SBR_IDX_DIVISOR, d, r);
    check({r, d}, {SBR_RESP_OKAY, 32'h0});
    rd(SBR_IDX_TX_CTRL, d, r);
    check({r, d}, {SBR_RESP_OKAY, 32'h2});
    rd(8'h00, d, r);
    check({r, d}, {SBR_RESP_SLVERR, 32'h0});
    wr(8'h00, 8'hFF, r);
    check(r, SBR_RESP_SLVERR);
    wr(SBR_IDX_RX_CTRL, 8'hFF, r);
    wr(SBR_IDX_TX_CTRL, 8'hFF, r);
    check(mode, 4'hF);
    rd(SBR_IDX_RX_CTRL, d, r);
    check(d, 32'hF8);
    // a frame in flight must show the shifter as full
    load <= 1'b1;
    @(posedge aclk);
    load <= 1'b0;
    rd(SBR_IDX_TX_CTRL, d, r);
    check(d, 32'hF5);
  endtask

  task automatic t_restart();
    logic [1:0] r;
    int n;
    wr(SBR_IDX_DIVISOR, 8'hFF, r);
    gap(1'b0, 400, n);
    check(n, 256);
    repeat (100) @(posedge aclk);
    wr(SBR_IDX_DIVISOR, 8'h0A, r);
    gap(1'b0, 400, n);
    check(n, 11);
    gap(1'b0, 400, n);
    check(n, 11);
    wr(SBR_IDX_DIVISOR, 8'h00, r);
    gap(1'b0, 400, n);
    gap(1'b0, 400, n);
    check(n, 1);
  endtask

  // one generator, four rate modes; divisor 2 keeps each period short
  task automatic t_modes();
    logic [7:0] tx [4] = '{8'h00, 8'h04, 8'h90, 8'h94};
    int pre [4] = '{SBR_PRE_ASYNC_LOW, SBR_PRE_ASYNC_HIGH, SBR_PRE_SYNC, SBR_PRE_SYNC};
    logic [1:0] r;
    int n;
    wr(SBR_IDX_RX_CTRL, 8'h80, r);
    for (int i = 0; i < 4; i++) begin
      wr(SBR_IDX_TX_CTRL, tx[i], r);
      wr(SBR_IDX_DIVISOR, 8'h02, r);
      check(mode, {tx[i][4], tx[i][7], tx[i][2], 1'b1});
      gap(1'b1, 2000, n);
      check(n, pre[i] * 3);
      gap(1'b1, 2000, n);
      check(n, pre[i] * 3);
    end
  endtask

  task automatic t_slave();
    logic [1:0] r;
    int n;
    wr(SBR_IDX_TX_CTRL, 8'h10, r);
    gap(1'b1, 1000, n);
    check(n, 1000);
    gap(1'b0, 100, n);
    gap(1'b0, 100, n);
    check(n, 3);
  endtask

  task automatic t_rereset();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SBR_IDX_DIVISOR, d, r);
    check(d, 32'h0);
  endtask

  task automatic close_out();
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // the whole run needs well under 20000 cycles
  initial begin
    #5000000;
    n_errors++;
    close_out();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, load} = 7'h0;
    {awaddr, araddr, wdata} = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_restart();
    t_modes();
    t_slave();
    t_rereset();
    close_out();
  end
endmodule
